// ===== cmxs_pkg.sv
// Package for the comparator input select register bank.
// Assumes a single system clock and an 8-bit special-function register bus.
package cmxs_pkg;

  // Special-function register page and addresses
  localparam logic [3:0] CMXS_SFR_PAGE = 4'h0;
  localparam logic [7:0] CMXS_CMP_ONE_ADDR = 8'h9E;
  localparam logic [7:0] CMXS_CMP_ZERO_ADDR = 8'h9F;

  // Reset value of both select registers
  localparam logic [7:0] CMXS_SEL_RESET = 8'hFF;

  // Field positions inside each select register
  localparam int CMXS_NEG_LSB = 4;
  localparam int CMXS_POS_LSB = 0;
  localparam int CMXS_FIELD_W = 4;

  // Field codes shared by positive and negative selects
  localparam logic [3:0] CMXS_CODE_PIN_LAST_NEG = 4'h6;
  localparam logic [3:0] CMXS_CODE_PIN_LAST_POS = 4'h7;
  localparam logic [3:0] CMXS_CODE_RSVD_FIRST = 4'h8;
  localparam logic [3:0] CMXS_CODE_RSVD_LAST = 4'hB;
  localparam logic [3:0] CMXS_CODE_TOUCH = 4'hC;
  localparam logic [3:0] CMXS_CODE_HALF = 4'hD;
  localparam logic [3:0] CMXS_CODE_SUPPLY_A = 4'hE;
  localparam logic [3:0] CMXS_CODE_SUPPLY_B = 4'hF;

  // Number of analog sources that a one-hot route can name
  localparam int CMXS_SRC_W = 13;

  // One-hot route bit positions
  localparam int CMXS_SRC_TOUCH = 8;
  localparam int CMXS_SRC_HALF = 9;
  localparam int CMXS_SRC_BATT = 10;
  localparam int CMXS_SRC_DIGITAL = 10;
  localparam int CMXS_SRC_MAIN = 11;
  localparam int CMXS_SRC_GROUND = 11;
  localparam int CMXS_SRC_RSVD = 12;

endpackage : cmxs_pkg

// ===== cmxs_field_decode.sv
// One select field decoded into a one-hot analog switch route.
// Assumes the caller supplies a four-bit field held in a register.
module cmxs_field_decode
  import cmxs_pkg::*;
#(
  parameter bit IS_NEG = 1'b0
) (
  input wire logic [3:0] code,
  output logic [cmxs_pkg::CMXS_SRC_W-1:0] route,
  output logic half_sel
);

  // Decode one code into one switch, or none when reserved
  always_comb begin
    route = '0;
    half_sel = 1'b0;
    // [RL8] Reserved connects nothing
    if (IS_NEG ? (code <= CMXS_CODE_PIN_LAST_NEG) : (code <= CMXS_CODE_PIN_LAST_POS)) begin
      // Pin switches, one for each pin code: 0 to 6 on negative, 0 to 7 on positive
      route[code[2:0]] = 1'b1;
    end else if (code == CMXS_CODE_TOUCH) begin
      route[CMXS_SRC_TOUCH] = 1'b1;
    end else if (code == CMXS_CODE_HALF) begin
      // [RL6] Half supply route
      route[CMXS_SRC_HALF] = 1'b1;
      half_sel = 1'b1;
    end else if (code == CMXS_CODE_SUPPLY_A) begin
      // Digital supply on negative, battery on positive
      route[IS_NEG ? CMXS_SRC_DIGITAL : CMXS_SRC_BATT] = 1'b1;
    end else if (code == CMXS_CODE_SUPPLY_B) begin
      // Ground on negative, main supply on positive
      route[IS_NEG ? CMXS_SRC_GROUND : CMXS_SRC_MAIN] = 1'b1;
    end
  end

endmodule : cmxs_field_decode

// ===== cmxs_regs.sv
// Comparator input select register bank on the special-function bus.
// Assumes the core presents page, address, write and read strobes on clock.
//
// Overview of operation
// [RL1] Zero select at page 0 0x9F, resets FF
// [RL2] Zero upper nibble picks negative source
// [RL3] Zero lower nibble picks positive source
// [RL4] One select at page 0 0x9E, resets FF
// [RL5] One select nibbles mirror zero encodings
// [RL6] Code 1101 routes half main supply
// [RL7] Divider on only when half selected
// [RL8] Reserved codes connect nothing, still read back
module cmxs_regs
  import cmxs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic [7:0] comparator_zero_input_select,
  output logic [7:0] comparator_one_input_select,
  output logic [cmxs_pkg::CMXS_SRC_W-1:0] cmp_zero_neg_route,
  output logic [cmxs_pkg::CMXS_SRC_W-1:0] cmp_zero_pos_route,
  output logic [cmxs_pkg::CMXS_SRC_W-1:0] cmp_one_neg_route,
  output logic [cmxs_pkg::CMXS_SRC_W-1:0] cmp_one_pos_route,
  output logic half_divider_en
);

  // Stored select registers
  logic [7:0] cmp_zero_sel_q;
  logic [7:0] cmp_one_sel_q;
  // Field views of the stored registers
  logic [3:0] cmp_zero_negative_field;
  logic [3:0] cmp_zero_positive_field;
  logic [3:0] cmp_one_negative_field;
  logic [3:0] cmp_one_positive_field;
  // Per-field half-supply requests
  logic [3:0] half_req;
  // Address matches
  logic hit_zero;
  logic hit_one;
  // Registered read data
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Decode an address on page 0 against one register address
  function automatic logic sfr_match(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] target);
    sfr_match = (pg == CMXS_SFR_PAGE) && (ad == target);
  endfunction : sfr_match

  assign hit_zero = sfr_match(sfr_page, sfr_addr, CMXS_CMP_ZERO_ADDR);
  assign hit_one = sfr_match(sfr_page, sfr_addr, CMXS_CMP_ONE_ADDR);
  // Combinational decode flag for the bus mux
  assign sfr_hit = hit_zero | hit_one;

  // Comparator zero select register
  always_ff @(posedge clock) begin
    // [RL1] Reset and write zero select
    if (rst) begin
      cmp_zero_sel_q <= CMXS_SEL_RESET;
    end else if (sfr_wr && hit_zero) begin
      // [RL8] Any code stored as written
      cmp_zero_sel_q <= sfr_wdata;
    end
  end

  // Comparator one select register
  always_ff @(posedge clock) begin
    // [RL4] Reset and write one select
    if (rst) begin
      cmp_one_sel_q <= CMXS_SEL_RESET;
    end else if (sfr_wr && hit_one) begin
      cmp_one_sel_q <= sfr_wdata;
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (hit_zero) begin
      rdata_d = cmp_zero_sel_q;
    end else if (hit_one) begin
      rdata_d = cmp_one_sel_q;
    end
  end

  // Read data register, loaded on a read strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      rdata_q <= rdata_d;
    end
  end
  assign sfr_rdata = rdata_q;

  // Register views for the analog side
  assign comparator_zero_input_select = cmp_zero_sel_q;
  assign comparator_one_input_select = cmp_one_sel_q;

  // [RL2] Negative field is bits 7:4
  assign cmp_zero_negative_field = cmp_zero_sel_q[CMXS_NEG_LSB +: CMXS_FIELD_W];
  // [RL3] Positive field is bits 3:0
  assign cmp_zero_positive_field = cmp_zero_sel_q[CMXS_POS_LSB +: CMXS_FIELD_W];
  // [RL5] Same layout for comparator one
  assign cmp_one_negative_field = cmp_one_sel_q[CMXS_NEG_LSB +: CMXS_FIELD_W];
  assign cmp_one_positive_field = cmp_one_sel_q[CMXS_POS_LSB +: CMXS_FIELD_W];

  // Comparator zero negative decode
  cmxs_field_decode #(.IS_NEG(1'b1)) u_zero_neg (
    .code(cmp_zero_negative_field),
    .route(cmp_zero_neg_route),
    .half_sel(half_req[0])
  );
  // Comparator zero positive decode
  cmxs_field_decode #(.IS_NEG(1'b0)) u_zero_pos (
    .code(cmp_zero_positive_field),
    .route(cmp_zero_pos_route),
    .half_sel(half_req[1])
  );
  // Comparator one negative decode
  cmxs_field_decode #(.IS_NEG(1'b1)) u_one_neg (
    .code(cmp_one_negative_field),
    .route(cmp_one_neg_route),
    .half_sel(half_req[2])
  );
  // Comparator one positive decode
  cmxs_field_decode #(.IS_NEG(1'b0)) u_one_pos (
    .code(cmp_one_positive_field),
    .route(cmp_one_pos_route),
    .half_sel(half_req[3])
  );

  // [RL7] Divider powered only on demand
  assign half_divider_en = |half_req;

  // Write requests that hit each select register
  sequence zero_write_s;
    sfr_wr && (sfr_page == CMXS_SFR_PAGE) && (sfr_addr == CMXS_CMP_ZERO_ADDR);
  endsequence
  sequence one_write_s;
    sfr_wr && (sfr_page == CMXS_SFR_PAGE) && (sfr_addr == CMXS_CMP_ONE_ADDR);
  endsequence

  // Read requests to each register and to anything unmapped
  sequence zero_read_s;
    sfr_rd && (sfr_page == CMXS_SFR_PAGE) && (sfr_addr == CMXS_CMP_ZERO_ADDR);
  endsequence
  sequence one_read_s;
    sfr_rd && (sfr_page == CMXS_SFR_PAGE) && (sfr_addr == CMXS_CMP_ONE_ADDR);
  endsequence
  sequence stray_read_s;
    sfr_rd && !((sfr_page == CMXS_SFR_PAGE) &&
      ((sfr_addr == CMXS_CMP_ZERO_ADDR) || (sfr_addr == CMXS_CMP_ONE_ADDR)));
  endsequence

  // Reset leaves both registers all ones
  reset_value_a: assert property (@(posedge clock) // [RL1]
    rst |=> (cmp_zero_sel_q == CMXS_SEL_RESET) && (cmp_one_sel_q == CMXS_SEL_RESET))
    else $error("select registers not all ones after reset");

  // A write to the zero address lands in the zero register next cycle
  zero_write_a: assert property (@(posedge clock) disable iff (rst) // [RL1]
    zero_write_s |=> (cmp_zero_sel_q == $past(sfr_wdata)))
    else $error("zero select write lost");

  // A write to the one address lands in the one register next cycle
  one_write_a: assert property (@(posedge clock) disable iff (rst) // [RL4]
    one_write_s |=> (cmp_one_sel_q == $past(sfr_wdata)))
    else $error("one select write lost");

  // Zero register holds when no write hits it, other pages included
  zero_hold_a: assert property (@(posedge clock) disable iff (rst) // [RL1]
    !(sfr_wr && (sfr_page == CMXS_SFR_PAGE) && (sfr_addr == CMXS_CMP_ZERO_ADDR)) |=> $stable(cmp_zero_sel_q))
    else $error("zero select changed without write");

  // One register holds when no write hits it, other pages included
  one_hold_a: assert property (@(posedge clock) disable iff (rst) // [RL4]
    !(sfr_wr && (sfr_page == CMXS_SFR_PAGE) && (sfr_addr == CMXS_CMP_ONE_ADDR)) |=> $stable(cmp_one_sel_q))
    else $error("one select changed without write");

  // Reads return the stored value one cycle later
  zero_read_a: assert property (@(posedge clock) disable iff (rst) // [RL1]
    zero_read_s |=> (sfr_rdata == $past(cmp_zero_sel_q)))
    else $error("zero select read back wrong");
  one_read_a: assert property (@(posedge clock) disable iff (rst) // [RL4]
    one_read_s |=> (sfr_rdata == $past(cmp_one_sel_q)))
    else $error("one select read back wrong");

  // Unmapped reads return zero
  stray_read_a: assert property (@(posedge clock) disable iff (rst) // [RL1]
    stray_read_s |=> (sfr_rdata == 8'h00))
    else $error("unmapped read not zero");

  // Ground code on the zero negative field
  neg_ground_a: assert property (@(posedge clock) disable iff (rst) // [RL2]
    (cmp_zero_sel_q[7:4] == 4'hF) |-> (cmp_zero_neg_route == 13'h0800))
    else $error("negative ground route wrong");

  // Pin code on the zero positive field picks that pin
  pos_pin_a: assert property (@(posedge clock) disable iff (rst) // [RL3]
    (cmp_zero_sel_q[3:0] < 4'h8) |-> (cmp_zero_pos_route == (13'h0001 << cmp_zero_sel_q[2:0])))
    else $error("positive pin route wrong");

  // Main supply code on the zero positive field
  pos_main_a: assert property (@(posedge clock) disable iff (rst) // [RL3]
    (cmp_zero_sel_q[3:0] == 4'hF) |-> (cmp_zero_pos_route == 13'h0800))
    else $error("positive main supply route wrong");

  // Comparator one positive battery code
  one_batt_a: assert property (@(posedge clock) disable iff (rst) // [RL5]
    (cmp_one_sel_q[3:0] == 4'hE) |-> (cmp_one_pos_route == 13'h0400))
    else $error("one positive battery route wrong");

  // Comparator one positive touch-sense code
  one_touch_a: assert property (@(posedge clock) disable iff (rst) // [RL5]
    (cmp_one_sel_q[3:0] == 4'hC) |-> (cmp_one_pos_route == 13'h0100))
    else $error("one positive touch route wrong");

  // Half code routes divider and powers it
  half_route_a: assert property (@(posedge clock) disable iff (rst) // [RL6]
    (cmp_one_sel_q[7:4] == 4'hD) |-> (cmp_one_neg_route == 13'h0200) && half_divider_en)
    else $error("half supply route wrong");

  // Divider off when no field holds the half code
  divider_off_a: assert property (@(posedge clock) disable iff (rst) // [RL7]
    (cmp_zero_sel_q[7:4] != 4'hD && cmp_zero_sel_q[3:0] != 4'hD &&
     cmp_one_sel_q[7:4] != 4'hD && cmp_one_sel_q[3:0] != 4'hD) |-> !half_divider_en)
    else $error("divider on without request");

  // Reserved negative code connects nothing
  rsvd_open_a: assert property (@(posedge clock) disable iff (rst) // [RL8]
    (cmp_zero_sel_q[7:4] == 4'h7 || (cmp_zero_sel_q[7:4] >= 4'h8 && cmp_zero_sel_q[7:4] <= 4'hB))
    |-> (cmp_zero_neg_route == 13'h0000))
    else $error("reserved code connected a source");

  // Reserved positive code connects nothing
  rsvd_pos_a: assert property (@(posedge clock) disable iff (rst) // [RL8]
    (cmp_one_sel_q[3:0] >= 4'h8 && cmp_one_sel_q[3:0] <= 4'hB) |-> (cmp_one_pos_route == 13'h0000))
    else $error("reserved positive code connected a source");

endmodule : cmxs_regs

// ===== cmxs_regs_test.sv
// Self-checking bench for the comparator input select register bank.
// Assumes cmxs_pkg and cmxs_regs are compiled first; one 200 MHz clock.
module cmxs_regs_test import cmxs_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst, sfr_wr, sfr_rd, sfr_hit, half_en, rd_seen;
  logic [3:0] sfr_page;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, zero_sel, one_sel, exp0, exp1, v, w;
  logic [CMXS_SRC_W-1:0] zn, zp, on, op;
  logic [7:0] notes[$]; // Expected read data, oldest first
  int fails, comparisons, cycles;

  cmxs_regs u_dut (.clock(clock), .rst(rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .comparator_zero_input_select(zero_sel), .comparator_one_input_select(one_sel),
    .cmp_zero_neg_route(zn), .cmp_zero_pos_route(zp), .cmp_one_neg_route(on), .cmp_one_pos_route(op),
    .half_divider_en(half_en));

  // Clock at 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Expected one-hot switch route of a field code
  function automatic logic [CMXS_SRC_W-1:0] route_of(input logic [3:0] c, input bit neg);
    if (c <= 4'h6 || (c == 4'h7 && !neg)) return 13'h0001 << c;
    if (c >= 4'hC) return 13'h0001 << (c - 4'h4);
    return 13'h0000;
  endfunction : route_of

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // One bus cycle; a read notes its expected data
  task automatic acc(input logic [3:0] pg, input logic [7:0] ad, input logic wr, input logic rd,
                     input logic [7:0] wd, input logic [7:0] exp_rd);
    logic hit_exp;
    hit_exp = (pg == CMXS_SFR_PAGE) && (ad == CMXS_CMP_ONE_ADDR || ad == CMXS_CMP_ZERO_ADDR);
    @(posedge clock);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_wr <= wr;
    sfr_rd <= rd;
    sfr_wdata <= wd;
    if (rd) notes.push_back(exp_rd);
    #1;
    chk(sfr_hit, hit_exp, "hit");
  endtask : acc

  task automatic idle();
    @(posedge clock);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask : idle

  // Registers, routes and divider against the bench's copy
  task automatic check_all();
    chk(zero_sel, exp0, "zero select");
    chk(one_sel, exp1, "one select");
    chk(zn, route_of(exp0[7:4], 1'b1), "zero neg route");
    chk(zp, route_of(exp0[3:0], 1'b0), "zero pos route");
    chk(on, route_of(exp1[7:4], 1'b1), "one neg route");
    chk(op, route_of(exp1[3:0], 1'b0), "one pos route");
    chk(half_en, 16'({exp0, exp1} inside {16'hD???, 16'h?D??, 16'h??D?, 16'h???D}), "divider");
  endtask : check_all

  // Takes the oldest note whenever read data appears
  always @(posedge clock) begin
    rd_seen <= sfr_rd && !rst;
    if (rd_seen) begin
      if (notes.size() == 0) chk(16'h0001, 16'h0000, "unexpected read");
      else chk(sfr_rdata, notes.pop_front(), "read data");
    end
  end

  // Cuts a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end

  // Main sequence of scenarios
  initial begin
    rst = 1'b1;
    {sfr_wr, sfr_rd} = 2'b00;
    {sfr_page, sfr_addr, sfr_wdata} = 20'h00000;
    void'($urandom(32'h358F));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    exp0 = CMXS_SEL_RESET;
    exp1 = CMXS_SEL_RESET;
    idle();
    check_all();
    // Every code in every field, then random values; zero select write and read share a cycle
    for (int n = 0; n < 48; n++) begin
      v = (n < 16) ? {n[3:0], n[3:0]} : 8'($urandom);
      w = (n < 16) ? {~n[3:0], n[3:0]} : 8'($urandom);
      acc(CMXS_SFR_PAGE, CMXS_CMP_ZERO_ADDR, 1'b1, 1'b1, v, exp0);
      exp0 = v;
      acc(CMXS_SFR_PAGE, CMXS_CMP_ONE_ADDR, 1'b1, 1'b0, w, 8'h00);
      exp1 = w;
      idle();
      check_all();
      acc(CMXS_SFR_PAGE, CMXS_CMP_ZERO_ADDR, 1'b0, 1'b1, 8'h00, exp0);
      acc(CMXS_SFR_PAGE, CMXS_CMP_ONE_ADDR, 1'b0, 1'b1, 8'h00, exp1);
    end
    // Other page and other addresses are ignored and read zero
    acc(4'h1, CMXS_CMP_ZERO_ADDR, 1'b1, 1'b1, 8'h00, 8'h00);
    acc(CMXS_SFR_PAGE, 8'h9D, 1'b1, 1'b1, 8'h00, 8'h00);
    acc(CMXS_SFR_PAGE, 8'hA0, 1'b1, 1'b1, 8'h00, 8'h00);
    idle();
    check_all();
    // Reset in mid-run restores all ones
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    exp0 = CMXS_SEL_RESET;
    exp1 = CMXS_SEL_RESET;
    #1;
    check_all();
    chk(sfr_rdata, 8'h00, "read data after reset");
    // Bus works again at the second edge after reset is released
    acc(CMXS_SFR_PAGE, CMXS_CMP_ZERO_ADDR, 1'b1, 1'b0, 8'h5D, 8'h00);
    exp0 = 8'h5D;
    acc(CMXS_SFR_PAGE, CMXS_CMP_ZERO_ADDR, 1'b0, 1'b1, 8'h00, exp0);
    idle();
    check_all();
    repeat (2) idle();
    // Every noted read must have been seen
    chk(16'(notes.size()), 16'h0000, "reads left unseen");
    wrap_up();
  end
endmodule : cmxs_regs_test
